//--- hw/fnd_defines.svh
`ifndef FND_DEFINES_SVH
`define FND_DEFINES_SVH

// --------------------------------------------------------------------
// Serial word layout
// --------------------------------------------------------------------
`define FND_WORD_W      24
`define FND_DATA_W      16
`define FND_ADDR_HI     23
`define FND_ADDR_LO     16
`define FND_RD_BIT      23
`define FND_IDX_HI      18
`define FND_UNMAP_LO    19
`define FND_UNMAP_HI    22
`define FND_NREG        8
`define FND_HDR_BITS    5'd8
`define FND_FULL_BITS   5'd24
`define FND_CNT_MAX     5'd31
`define FND_RST_WORD    16'h0000

// --------------------------------------------------------------------
// Register indices
// --------------------------------------------------------------------
`define FND_REG_INT     3'h0
`define FND_REG_P1_LO   3'h1
`define FND_REG_P1_HI   3'h2
`define FND_REG_AUXNUM  3'h3
`define FND_REG_AUXDEN  3'h4
`define FND_REG_REFCFG  3'h5
`define FND_REG_OUTCFG  3'h6

// --------------------------------------------------------------------
// Field positions and widths
// --------------------------------------------------------------------
`define FND_P1_W        25
`define FND_P1_HI_W     9
`define FND_AUX_W       14
`define FND_RCNT_W      10
`define FND_DBL_BIT     10
`define FND_HALF_BIT    11
`define FND_RFSEL_LSB   0
`define FND_RFSEL_MSB   2
`define FND_MON_LSB     3
`define FND_MON_MSB     4
`define FND_RB_EN_BIT   5
`define FND_FALL_BIT    6

// --------------------------------------------------------------------
// Synchronised pin slots and feedback divider width
// --------------------------------------------------------------------
`define FND_S_SCLK      0
`define FND_S_SDIO      1
`define FND_S_CSN       2
`define FND_S_REF       3
`define FND_S_RFS       4
`define FND_S_DLD       5
`define FND_S_ALD       6
`define FND_NSYNC       7
`define FND_NDIV_W      17

`endif

//--- hw/fnd_pkg.sv
`include "fnd_defines.svh"

package fnd_pkg;

  // ------------------------------------------------------------------
  // Monitor pin source
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    FND_MON_DLD = 2'h0,
    FND_MON_ALD = 2'h1,
    FND_MON_RF  = 2'h2,
    FND_MON_REF = 2'h3
  } fnd_mon_t;

  // ------------------------------------------------------------------
  // Whole state of the control block
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][`FND_NSYNC-1:0]              sy;
    logic [`FND_NSYNC-1:0]                   flt;
    logic [`FND_WORD_W-1:0]                  shreg;
    logic [4:0]                              bitcnt;
    logic [`FND_NREG-1:0][`FND_DATA_W-1:0]   regs;
    logic [`FND_DATA_W-1:0]                  rb;
    logic                                    rb_act;
    logic [`FND_RCNT_W-1:0]                  ref_cnt;
    logic                                    ref_half;
    logic [`FND_P1_W-1:0]                    acc1;
    logic [`FND_AUX_W-1:0]                   acc2;
    logic [`FND_NDIV_W-1:0]                  ndiv;
    logic                                    pfd_tick;
    logic                                    ref_tgl;
    logic                                    mon;
  } fnd_state_t;

endpackage : fnd_pkg

//--- hw/fnd_ctrl.sv
`timescale 1ns/1ps
`include "fnd_defines.svh"

// Operation
// - Shift serial data into 24-bit register on the chosen clock edge.
// - On load strobe rising, copy shifted data into addressed register.
// - Monitor pin selects digital lock, analog lock, scaled RF or ref.
// - In four-wire mode, register contents are driven out on monitor.
// - Output equals pfd times (int plus fraction over modulus) over divider.
// - Primary modulus is fixed at 2^25, never programmable.
// - Pfd equals reference times (1+doubler) over counter times (1+halve).
// - Halving bit set divides reference path by a further two.
// - Feedback ratio taken before output divider, oscillator over pfd.
module fnd_ctrl
  import fnd_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  input  wire logic                    sclk_i,
  input  wire logic                    sdio_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    reference_clock_in_i,
  input  wire logic                    rf_scaled_i,
  input  wire logic                    dig_lock_i,
  input  wire logic                    ana_lock_i,
  output logic                         monitor_pin_o,
  output logic                         pfd_tick_o,
  output logic [`FND_NDIV_W-1:0]       feedback_div_o,
  output logic [2:0]                   rf_div_sel_o
);

  fnd_state_t st_r;
  fnd_state_t st_nxt;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : rose

  function automatic logic fell(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction : fell

  logic [`FND_NSYNC-1:0] pins;
  assign pins = {ana_lock_i, dig_lock_i, rf_scaled_i, reference_clock_in_i,
                 cs_n_i, sdio_i, sclk_i};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic                       smp;
    logic                       ref_edge;
    logic                       cs_rise;
    logic                       rd_req;
    logic [`FND_DATA_W-1:0]     cfg_ref;
    logic [`FND_DATA_W-1:0]     cfg_out;
    logic [`FND_RCNT_W-1:0]     rlim;
    logic [`FND_AUX_W:0]        s2;
    logic                       c2;
    logic [`FND_P1_W:0]         s1;
    logic [`FND_P1_W-1:0]       primary_numerator;
    logic [`FND_AUX_W-1:0]      fnum2;
    logic [`FND_AUX_W-1:0]      fden2;
    smp      = 1'b0;
    ref_edge = 1'b0;
    cs_rise  = 1'b0;
    rd_req   = 1'b0;
    s2       = '0;
    c2       = 1'b0;
    s1       = '0;
    st_nxt   = st_r;
    cfg_ref  = st_r.regs[`FND_REG_REFCFG];
    cfg_out  = st_r.regs[`FND_REG_OUTCFG];
    rlim     = cfg_ref[`FND_RCNT_W-1:0];
    primary_numerator    = {st_r.regs[`FND_REG_P1_HI][`FND_P1_HI_W-1:0],
                st_r.regs[`FND_REG_P1_LO]};
    fnum2    = st_r.regs[`FND_REG_AUXNUM][`FND_AUX_W-1:0];
    fden2    = st_r.regs[`FND_REG_AUXDEN][`FND_AUX_W-1:0];

    // Three-stage pin sync; a change counts once stages 2 and 3 agree
    st_nxt.sy[0] = pins;
    st_nxt.sy[1] = st_r.sy[0];
    st_nxt.sy[2] = st_r.sy[1];
    for (int i = 0; i < `FND_NSYNC; i++)
    begin
      if (st_r.sy[1][i] == st_r.sy[2][i])
      begin
        st_nxt.flt[i] = st_r.sy[2][i];
      end
    end

    smp = cfg_out[`FND_FALL_BIT]
        ? fell(st_nxt.flt[`FND_S_SCLK], st_r.flt[`FND_S_SCLK])
        : rose(st_nxt.flt[`FND_S_SCLK], st_r.flt[`FND_S_SCLK]);
    cs_rise = rose(st_nxt.flt[`FND_S_CSN], st_r.flt[`FND_S_CSN]);

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    if (st_r.flt[`FND_S_CSN])
    begin
      st_nxt.bitcnt = '0;
      st_nxt.rb_act = 1'b0;
    end
    else if (smp)
    begin
      st_nxt.shreg  = {st_r.shreg[`FND_WORD_W-2:0], st_r.flt[`FND_S_SDIO]};
      if (st_r.bitcnt != `FND_CNT_MAX)
      begin
        st_nxt.bitcnt = st_r.bitcnt + 5'd1;
      end
      st_nxt.rb = {st_r.rb[`FND_DATA_W-2:0], 1'b0};
      // load readback word after the address byte
      if (st_nxt.bitcnt == `FND_HDR_BITS && cfg_out[`FND_RB_EN_BIT] &&
          st_nxt.shreg[`FND_HDR_BITS-5'd1])
      begin
        st_nxt.rb     = st_r.regs[st_nxt.shreg[`FND_IDX_HI-`FND_ADDR_LO:0]];
        st_nxt.rb_act = 1'b1;
      end
    end

    // load strobe release writes the addressed register
    rd_req = st_r.shreg[`FND_RD_BIT];
    if (cs_rise && st_r.bitcnt == `FND_FULL_BITS && !rd_req &&
        st_r.shreg[`FND_UNMAP_HI:`FND_UNMAP_LO] == '0)
    begin
      st_nxt.regs[st_r.shreg[`FND_IDX_HI:`FND_ADDR_LO]] =
        st_r.shreg[`FND_DATA_W-1:0];
    end

    // ------------------------------------------------------------------
    // Reference path
    // ------------------------------------------------------------------
    // doubler counts both reference edges
    ref_edge = cfg_ref[`FND_DBL_BIT]
             ? (st_nxt.flt[`FND_S_REF] ^ st_r.flt[`FND_S_REF])
             : rose(st_nxt.flt[`FND_S_REF], st_r.flt[`FND_S_REF]);
    st_nxt.pfd_tick = 1'b0;
    if (ref_edge)
    begin
      // divide by reference counter, zero taken as one
      if (st_r.ref_cnt + 10'd1 >= rlim)
      begin
        st_nxt.ref_cnt  = '0;
        st_nxt.ref_half = ~st_r.ref_half;
        // halving passes every second terminal count
        if (!cfg_ref[`FND_HALF_BIT] || st_r.ref_half)
        begin
          st_nxt.pfd_tick = 1'b1;
        end
      end
      else
      begin
        st_nxt.ref_cnt = st_r.ref_cnt + 10'd1;
      end
    end

    // ------------------------------------------------------------------
    // Fractional feedback divider
    // ------------------------------------------------------------------
    if (st_nxt.pfd_tick)
    begin
      st_nxt.ref_tgl = ~st_r.ref_tgl;
      // auxiliary numerator over auxiliary modulus feeds the carry
      s2 = {1'b0, st_r.acc2} + {1'b0, fnum2};
      if (fden2 != '0 && s2 >= {1'b0, fden2})
      begin
        c2 = 1'b1;
        s2 = s2 - {1'b0, fden2};
      end
      st_nxt.acc2 = s2[`FND_AUX_W-1:0];
      s1 = {1'b0, st_r.acc1} + {1'b0, primary_numerator} + {{`FND_P1_W{1'b0}}, c2};
      st_nxt.acc1 = s1[`FND_P1_W-1:0];
      // ratio applies to oscillator before output divider
      st_nxt.ndiv = {1'b0, st_r.regs[`FND_REG_INT]} +
                    {{(`FND_NDIV_W-1){1'b0}}, s1[`FND_P1_W]};
    end

    // ------------------------------------------------------------------
    // Monitor pin
    // ------------------------------------------------------------------
    // readback overrides the monitor source
    if (st_nxt.rb_act)
    begin
      st_nxt.mon = st_nxt.rb[`FND_DATA_W-1];
    end
    else
    begin
      case (fnd_mon_t'(cfg_out[`FND_MON_MSB:`FND_MON_LSB]))
        FND_MON_DLD: st_nxt.mon = st_nxt.flt[`FND_S_DLD];
        FND_MON_ALD: st_nxt.mon = st_nxt.flt[`FND_S_ALD];
        FND_MON_RF:  st_nxt.mon = st_nxt.flt[`FND_S_RFS];
        FND_MON_REF: st_nxt.mon = st_nxt.ref_tgl;
        default:     st_nxt.mon = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r                   <= '0;
      // Strobe idles high, so no false release follows reset
      st_r.sy[0][`FND_S_CSN] <= 1'b1;
      st_r.sy[1][`FND_S_CSN] <= 1'b1;
      st_r.sy[2][`FND_S_CSN] <= 1'b1;
      st_r.flt[`FND_S_CSN]   <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign monitor_pin_o  = st_r.mon;
  assign pfd_tick_o     = st_r.pfd_tick;
  assign feedback_div_o = st_r.ndiv;
  assign rf_div_sel_o   =
    st_r.regs[`FND_REG_OUTCFG][`FND_RFSEL_MSB:`FND_RFSEL_LSB];

endmodule : fnd_ctrl

//--- sim/fnd_ctrl_chk.sv
`timescale 1ns/1ps
`include "fnd_defines.svh"
module fnd_ctrl_chk
(
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic                   sclk_i,
  input wire logic                   sdio_i,
  input wire logic                   cs_n_i,
  input wire logic                   reference_clock_in_i,
  input wire logic                   rf_scaled_i,
  input wire logic                   dig_lock_i,
  input wire logic                   ana_lock_i,
  input wire logic                   monitor_pin_o,
  input wire logic                   pfd_tick_o,
  input wire logic [`FND_NDIV_W-1:0] feedback_div_o,
  input wire logic [2:0]             rf_div_sel_o
);
  logic [5:0] pin_r;
  logic [3:0] ref_age_r;
  logic [3:0] src_age_r;
  wire  [5:0] pin = {reference_clock_in_i, cs_n_i, sclk_i, dig_lock_i,
                     ana_lock_i, rf_scaled_i};

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----
  // Cycles since last pin edge
  // ----
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      pin_r     <= '0;
      ref_age_r <= 4'hf;
      src_age_r <= 4'hf;
    end
    else
    begin
      pin_r     <= pin;
      ref_age_r <= (pin[5] != pin_r[5]) ? 4'h0 :
                   ref_age_r + 4'(ref_age_r != 4'hf);
      src_age_r <= (pin != pin_r) ? 4'h0 :
                   src_age_r + 4'(src_age_r != 4'hf);
    end

  property p_tick_gap; pfd_tick_o |=> !pfd_tick_o [*8]; endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("tick gap");
  property p_tick_src; pfd_tick_o |-> ref_age_r inside {[1:8]}; endproperty
  a_tick_src: assert property (p_tick_src)
    else $error("tick without ref edge");
  property p_div_hold; !pfd_tick_o |-> $stable(feedback_div_o); endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divide value moved");
  property p_sel_wait; $rose(cs_n_i) |=> $stable(rf_div_sel_o) [*3];
  endproperty
  a_sel_wait: assert property (p_sel_wait)
    else $error("write too early");
  property p_sel_cause; $changed(rf_div_sel_o) |->
    cs_n_i && $past(cs_n_i, 4) && !$past(cs_n_i, 8); endproperty
  a_sel_cause: assert property (p_sel_cause)
    else $error("write without strobe rise");
  property p_rst_out; $past(rst_i) |-> !pfd_tick_o && !monitor_pin_o &&
    feedback_div_o == '0 && rf_div_sel_o == 3'h0; endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared");
  property p_mon_cause; $changed(monitor_pin_o) |-> src_age_r <= 4'h8;
  endproperty
  a_mon_cause: assert property (p_mon_cause)
    else $error("monitor moved without cause");
  property p_mon_rate; $changed(monitor_pin_o) && !cs_n_i |=>
    $stable(monitor_pin_o) [*8]; endproperty
  a_mon_rate: assert property (p_mon_rate)
    else $error("readback bit too short");

  c_tick: cover property (pfd_tick_o);
  c_sel: cover property ($changed(rf_div_sel_o));
  c_div: cover property ($changed(feedback_div_o));
endmodule : fnd_ctrl_chk

//--- sim/fnd_host.sv
`timescale 1ns/1ps
module fnd_host
(
  input  wire logic mclk_i,
  input  wire logic mon_i,
  output logic      sclk_o,
  output logic      sdio_o,
  output logic      cs_n_o
);
  initial
  begin
    sclk_o = 1'b0;
    sdio_o = 1'b0;
    cs_n_o = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tk

  // Frame, MSB first; fe moves data after the rise
  task automatic xfer(input logic [23:0] w, input int nb, input logic fe,
                      output logic [15:0] rd);
    rd = 16'h0000;
    cs_n_o = 1'b0;
    tk(6);
    for (int k = 0; k < nb; k++)
    begin
      if (!fe)
        sdio_o = w[23-k];
      tk(6);
      if (k >= 8)
        rd = {rd[14:0], mon_i};
      sclk_o = 1'b1;
      tk(6);
      if (fe)
        sdio_o = w[23-k];
      tk(7);
      sclk_o = 1'b0;
      tk(6);
    end
    cs_n_o = 1'b1;
    sdio_o = ~sdio_o;
    tk(12);
  endtask : xfer
endmodule : fnd_host

//--- sim/fnd_ctrl_tb.sv
`timescale 1ns/1ps
`include "fnd_defines.svh"
module fnd_ctrl_tb;
  logic                   mclk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   reference_clock_in_i = 1'b0;
  logic                   rf_scaled_i = 1'b0;
  logic                   dig_lock_i = 1'b0;
  logic                   ana_lock_i = 1'b0;
  logic                   sclk_i, sdio_i, cs_n_i, monitor_pin_o, pfd_tick_o;
  logic [`FND_NDIV_W-1:0] feedback_div_o, a, b;
  logic [2:0]             rf_div_sel_o;
  logic [15:0]            rd, iv, v;
  int                     bad_count = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  int                     seed = 32'hea616a88;
  int                     r, n;
  logic                   ref_run = 1'b1;
  localparam int          FR_P1   = 32'h0055_5555;
  localparam int          FR_NUM  = 32'h0000_0001;
  localparam int          FR_DEN  = 32'h0000_0003;

  fnd_ctrl uut (.mclk_i, .rst_i, .sclk_i, .sdio_i, .cs_n_i,
    .reference_clock_in_i, .rf_scaled_i, .dig_lock_i, .ana_lock_i,
    .monitor_pin_o, .pfd_tick_o, .feedback_div_o, .rf_div_sel_o);
  fnd_host host (.mclk_i, .mon_i(monitor_pin_o), .sclk_o(sclk_i),
    .sdio_o(sdio_i), .cs_n_o(cs_n_i));

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Reference at 20 cycles a period, and the hang limit
  always @(negedge mclk_i)
  begin
    cyc = cyc + 1;
    if (cyc % 10 == 0 && (ref_run || reference_clock_in_i))
      reference_clock_in_i = ~reference_clock_in_i;
    if (cyc == 30000)
    begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  task automatic chk(input string s, input logic [16:0] e,
                     input logic [16:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    host.xfer({5'h00, idx, d}, 24, 1'b0, rd);
  endtask : wr

  task automatic gap(output int c);
    c = 0;
    while (pfd_tick_o !== 1'b1)
      @(negedge mclk_i);
    do
    begin
      @(negedge mclk_i);
      c++;
    end
    while (pfd_tick_o !== 1'b1);
  endtask : gap

  function automatic logic mon_exp(int s);
    return (s == 0) ? dig_lock_i : (s == 1) ? ana_lock_i : rf_scaled_i;
  endfunction : mon_exp

  // Carries of the two-level accumulator over the first t ticks
  function automatic int n_carry(input int t);
    longint acc;
    acc = longint'(t) * FR_P1 + (t * FR_NUM) / FR_DEN;
    return int'(acc >>> `FND_P1_W);
  endfunction : n_carry

  task automatic complete_run();
    $display("TB: checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    for (int m = 0; m < 4; m++)
    begin
      r = 1 + $unsigned($random(seed)) % 6;
      wr(3'h5, {4'h0, m[1], m[0], 10'(r)});
      gap(n);
      gap(n);
      chk("pfd_gap", 17'(r * 10 * (2 - m[0]) * (1 + m[1])), 17'(n));
    end
    iv = 16'($random(seed));
    wr(3'h0, iv);
    wr(3'h1, 16'h0000);
    wr(3'h2, 16'h0100);
    gap(n);
    a = feedback_div_o;
    gap(n);
    b = feedback_div_o;
    chk("div_pair", 17'(iv) * 2 + 17'h1, a + b);
    for (int s = 0; s < 4; s++)
    begin
      v = {11'h0, 2'(s), 3'($random(seed))};
      wr(3'h6, v);
      chk("div_sel", 17'(v[2:0]), 17'(rf_div_sel_o));
      for (int k = 0; k < 2 && s < 3; k++)
      begin
        {dig_lock_i, ana_lock_i, rf_scaled_i} = (k == 0) ?
          3'($random(seed)) : ~{dig_lock_i, ana_lock_i, rf_scaled_i};
        repeat (8) @(negedge mclk_i);
        chk("mon_src", 17'(mon_exp(s)), 17'(monitor_pin_o));
      end
    end
    gap(n);
    a[0] = monitor_pin_o;
    gap(n);
    chk("mon_ref", 17'(!a[0]), 17'(monitor_pin_o));
    host.xfer({5'h01, 3'h6, v ^ 16'h0007}, 24, 1'b0, rd);
    host.xfer({5'h00, 3'h6, v ^ 16'h0007}, 23, 1'b0, rd);
    chk("refused", 17'(v[2:0]), 17'(rf_div_sel_o));
    v = 16'h0025;
    wr(3'h6, v);
    host.xfer(24'h860000, 24, 1'b0, rd);
    chk("rb_out", 17'(v), 17'(rd));
    host.xfer(24'h800000, 24, 1'b0, rd);
    chk("rb_int", 17'(iv), 17'(rd));
    wr(3'h6, 16'h0041);
    host.xfer(24'h060046, 24, 1'b1, rd);
    chk("fall_edge", 17'h6, 17'(rf_div_sel_o));
    // Fresh accumulators: park the reference low, reset mid-run
    ref_run = 1'b0;
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    wr(3'h0, iv);
    wr(3'h1, 16'(FR_P1));
    wr(3'h2, 16'(FR_P1 >> 16));
    wr(3'h3, 16'(FR_NUM));
    wr(3'h4, 16'(FR_DEN));
    ref_run = 1'b1;
    for (int t = 1; t <= 6; t++)
    begin
      while (pfd_tick_o !== 1'b1)
        @(negedge mclk_i);
      a = 17'(iv) + 17'(n_carry(t) - n_carry(t - 1));
      chk("aux_div", a, feedback_div_o);
      @(negedge mclk_i);
    end
    complete_run();
  end
endmodule : fnd_ctrl_tb

bind fnd_ctrl fnd_ctrl_chk chk (.mclk_i, .rst_i, .sclk_i, .sdio_i, .cs_n_i,
  .reference_clock_in_i, .rf_scaled_i, .dig_lock_i, .ana_lock_i,
  .monitor_pin_o, .pfd_tick_o, .feedback_div_o, .rf_div_sel_o);
